// ---- design/ebm_reset_seq.sv ----
// Reset and power-state sequencer driven by enable pin and battery monitor.
// Assumes all inputs synchronous to clk; enable and pad levels come as digital flags.
`timescale 1ns/1ps
`include "ebm_params.svh"

// Notes on behaviour
// - Monitor on and battery below critical level moves device to monitor state.
// - Monitor enable comes from the nonvolatile configuration word.
// - Monitor is off at first start-up until configuration requests it.
// - Battery level is compared every cycle while monitoring.
// - Two selectable critical levels, about 150 mV hysteresis.
// - Enable pin low gives hard power-down with reset held.
// - Battery reset gives monitor state only while enable pin is high.
// - Reset restarts firmware and returns registers to defaults.
// - Some defaults come from configuration, others fixed in hardware.
// - Leave reset only with enable high and battery fine if monitored.
// - Pad supply loss marks latched interface choice invalid until reboot.
module ebm_reset_seq #(
   parameter int SEL_W      = 2,
   parameter int HOLD_COUNT = `EBM_HOLD_CYCLES
) (
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                chip_enable_pin,
   input  wire ebm_pkg::ebm_mv_t    battery_mv,
   input  wire logic                pad_supply_ok,
   input  wire logic                cfg_loaded,
   input  wire logic [15:0]         cfg_word,
   input  wire logic [SEL_W-1:0]    iface_sel_pins,
   output logic                     core_rst_b,
   output logic                     fw_restart,
   output logic                     hard_power_down,
   output logic                     monitor_state,
   output logic                     monitor_enabled,
   output logic [7:0]               cfg_defaults,
   output logic [7:0]               hw_defaults,
   output logic [SEL_W-1:0]         iface_sel,
   output logic                     iface_sel_valid,
   output ebm_pkg::ebm_state_e      state
);
   // Hold counter is 8 bits and saturates, so larger counts cannot be served
   if (HOLD_COUNT < 1 || HOLD_COUNT > 255 || SEL_W < 1) begin : g_bad_params
      $error("HOLD_COUNT or SEL_W out of range");
   end

   ebm_pkg::ebm_state_e state_q;
   ebm_pkg::ebm_state_e state_d;
   logic                mon_en_q;
   logic                level_sel_q;
   logic                battery_low;
   logic [7:0]          hold_q;
   logic [7:0]          cfg_def_q;
   logic [7:0]          cfg_def_d;
   logic [7:0]          cfg_out_q;
   logic                core_rst_b_q;
   logic                fw_restart_q;
   logic                pad_q;
   logic                pad_lost;
   logic                capture;
   logic                cause;

   // Configuration flags start cleared so the monitor is off at first power-up
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mon_en_q    <= 1'b0;
         level_sel_q <= 1'b0;
         cfg_def_q   <= 8'h00;
      end else if (cfg_loaded) begin
         mon_en_q    <= cfg_word[`EBM_CFG_MON_EN_BIT];
         level_sel_q <= cfg_word[`EBM_CFG_LEVEL_SEL_BIT];
         cfg_def_q   <= cfg_word[`EBM_CFG_DEFAULTS_MSB:`EBM_CFG_DEFAULTS_LSB];
      end
   end

   assign cfg_def_d = cfg_loaded ? cfg_word[`EBM_CFG_DEFAULTS_MSB:`EBM_CFG_DEFAULTS_LSB]
                                 : cfg_def_q;

   ebm_battery_cmp u_cmp (
      .clk         (clk),
      .rst_b       (rst_b),
      .enable      (mon_en_q),
      .level_sel   (level_sel_q),
      .battery_mv  (battery_mv),
      .battery_low (battery_low)
   );

   // Any live cause keeps the core in reset
   assign cause = !chip_enable_pin || (mon_en_q && battery_low);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ebm_pkg::EBM_POWER_DOWN: begin
            if (chip_enable_pin && mon_en_q && battery_low) begin
               state_d = ebm_pkg::EBM_MONITOR;
            end else if (chip_enable_pin) begin
               state_d = ebm_pkg::EBM_HOLD;
            end
         end
         ebm_pkg::EBM_MONITOR: begin
            if (!chip_enable_pin) begin
               state_d = ebm_pkg::EBM_POWER_DOWN;
            end else if (!(mon_en_q && battery_low)) begin
               state_d = ebm_pkg::EBM_HOLD;
            end
         end
         ebm_pkg::EBM_HOLD: begin
            if (!chip_enable_pin) begin
               state_d = ebm_pkg::EBM_POWER_DOWN;
            end else if (mon_en_q && battery_low) begin
               state_d = ebm_pkg::EBM_MONITOR;
            end else if (hold_q == 8'(HOLD_COUNT - 1)) begin
               state_d = ebm_pkg::EBM_RUN;
            end
         end
         ebm_pkg::EBM_RUN: begin
            if (!chip_enable_pin) begin
               state_d = ebm_pkg::EBM_POWER_DOWN;
            end else if (mon_en_q && battery_low) begin
               state_d = ebm_pkg::EBM_MONITOR;
            end
         end
         default: begin
            state_d = ebm_pkg::EBM_POWER_DOWN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ebm_pkg::EBM_POWER_DOWN;
      end else begin
         state_q <= state_d;
      end
   end

   // Hold counter guarantees a minimum reset width after causes clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_q <= 8'h00;
      end else if (state_q != ebm_pkg::EBM_HOLD || cause) begin
         hold_q <= 8'h00;
      end else if (hold_q != 8'hff) begin
         hold_q <= hold_q + 8'h01;
      end
   end

   assign capture = (state_q == ebm_pkg::EBM_HOLD) && (state_d == ebm_pkg::EBM_RUN);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         core_rst_b_q <= 1'b0;
         fw_restart_q <= 1'b0;
      end else begin
         core_rst_b_q <= (state_d == ebm_pkg::EBM_RUN);
         fw_restart_q <= capture;
      end
   end

   // Zero while held; a load in the release cycle is already visible
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_out_q <= 8'h00;
      end else if (state_d == ebm_pkg::EBM_RUN) begin
         cfg_out_q <= cfg_def_d;
      end else begin
         cfg_out_q <= 8'h00;
      end
   end

   // Pad supply falling edge while powered; boot recovery is left to the host
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pad_q <= 1'b0;
      end else begin
         pad_q <= pad_supply_ok;
      end
   end
   assign pad_lost = pad_q && !pad_supply_ok;

   ebm_iface_latch #(
      .SEL_W (SEL_W)
   ) u_latch (
      .clk       (clk),
      .rst_b     (rst_b),
      .capture   (capture),
      .pad_lost  (pad_lost),
      .sel_pins  (iface_sel_pins),
      .sel_q     (iface_sel),
      .sel_valid (iface_sel_valid)
   );

   assign core_rst_b      = core_rst_b_q;
   assign fw_restart      = fw_restart_q;
   assign hard_power_down = (state_q == ebm_pkg::EBM_POWER_DOWN);
   assign monitor_state   = (state_q == ebm_pkg::EBM_MONITOR);
   assign monitor_enabled = mon_en_q;
   // Defaults read as stored values only while the core runs
   assign cfg_defaults    = cfg_out_q;
   assign hw_defaults     = 8'(`EBM_HW_DEFAULTS);
   assign state           = state_q;

   enable_low_pd_a: assert property (@(posedge clk) disable iff (!rst_b)
      !chip_enable_pin |=> hard_power_down && !core_rst_b)
      else $error("enable low without hard power-down");

   batt_monitor_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_q == ebm_pkg::EBM_RUN && chip_enable_pin && mon_en_q && battery_low)
      |=> monitor_state)
      else $error("low battery did not enter monitor state");

   monitor_needs_en_a: assert property (@(posedge clk) disable iff (!rst_b)
      monitor_state |-> $past(chip_enable_pin))
      else $error("monitor state without enable high");

   release_cond_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(core_rst_b) |-> $past(chip_enable_pin) && !$past(mon_en_q && battery_low))
      else $error("reset released with a cause present");

   hold_min_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(core_rst_b) |-> $past(state_q == ebm_pkg::EBM_HOLD))
      else $error("reset released without hold phase");

   cause_holds_a: assert property (@(posedge clk) disable iff (!rst_b)
      cause |=> !core_rst_b)
      else $error("core out of reset while cause present");

   fw_restart_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(core_rst_b) |-> fw_restart ##1 !fw_restart)
      else $error("firmware restart pulse missing at release");

   mon_cfg_a: assert property (@(posedge clk) disable iff (!rst_b)
      cfg_loaded |=> monitor_enabled == $past(cfg_word[`EBM_CFG_MON_EN_BIT]))
      else $error("monitor enable does not follow configuration");

   sel_kept_a: assert property (@(posedge clk) disable iff (!rst_b)
      (core_rst_b && $past(core_rst_b)) |-> $stable(iface_sel))
      else $error("interface selection changed while running");

   hold_len_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(core_rst_b) |-> $past(hold_q) == 8'(HOLD_COUNT - 1))
      else $error("reset released before the hold count ran out");

   hold_in_reset_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state == ebm_pkg::EBM_HOLD) |-> !core_rst_b)
      else $error("core out of reset during hold phase");

   pd_in_reset_a: assert property (@(posedge clk) disable iff (!rst_b)
      hard_power_down |-> !core_rst_b)
      else $error("core out of reset in hard power-down");

   mon_in_reset_a: assert property (@(posedge clk) disable iff (!rst_b)
      monitor_state |-> !core_rst_b)
      else $error("core out of reset in monitor state");

   bat_cause_en_a: assert property (@(posedge clk) disable iff (!rst_b)
      (chip_enable_pin && mon_en_q && battery_low) |=> monitor_state)
      else $error("battery cause with enable high did not give monitor state");

   mon_off_cmp_a: assert property (@(posedge clk) disable iff (!rst_b)
      !mon_en_q |=> !battery_low)
      else $error("battery low flagged while monitor is off");

   cfg_stable_a: assert property (@(posedge clk) disable iff (!rst_b)
      !cfg_loaded |=> $stable(monitor_enabled))
      else $error("monitor enable changed without a configuration load");

   run_needs_en_a: assert property (@(posedge clk) disable iff (!rst_b)
      core_rst_b |-> $past(chip_enable_pin))
      else $error("core running after enable was low");

   run_no_low_a: assert property (@(posedge clk) disable iff (!rst_b)
      core_rst_b |-> !$past(mon_en_q && battery_low))
      else $error("core running with monitored battery low");

   pd_to_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      (hard_power_down && chip_enable_pin && !(mon_en_q && battery_low))
      |=> (state == ebm_pkg::EBM_HOLD))
      else $error("enable high did not start the hold phase");

   leave_mon_a: assert property (@(posedge clk) disable iff (!rst_b)
      (monitor_state && chip_enable_pin && !(mon_en_q && battery_low))
      |=> (state == ebm_pkg::EBM_HOLD))
      else $error("battery recovery did not leave monitor state");

   fw_at_release_a: assert property (@(posedge clk) disable iff (!rst_b)
      fw_restart |-> core_rst_b && !$past(core_rst_b))
      else $error("firmware restart pulse away from release");

   reset_zero_def_a: assert property (@(posedge clk) disable iff (!rst_b)
      !core_rst_b |-> cfg_defaults == 8'h00)
      else $error("stored defaults visible while core in reset");

   cfg_def_load_a: assert property (@(posedge clk) disable iff (!rst_b)
      (core_rst_b && $past(cfg_loaded))
      |-> cfg_defaults == $past(cfg_word[`EBM_CFG_DEFAULTS_MSB:`EBM_CFG_DEFAULTS_LSB]))
      else $error("loaded defaults not shown while running");

   sel_capture_a: assert property (@(posedge clk) disable iff (!rst_b)
      fw_restart |-> iface_sel == $past(iface_sel_pins))
      else $error("interface selection not taken at release");

   valid_on_boot_a: assert property (@(posedge clk) disable iff (!rst_b)
      (fw_restart && !$past(pad_lost)) |-> iface_sel_valid)
      else $error("selection not valid after a clean boot");
endmodule // ebm_reset_seq

// ---- pkg/ebm_params.svh ----
// Constants for the enable and battery monitor reset sequencer.
// Assumes inclusion by bare name; definitions only.
`ifndef EBM_PARAMS_SVH
`define EBM_PARAMS_SVH

// Battery level codes in millivolts, compared against a digital level input
`define EBM_LEVEL_LOW_MV      16'h08fc
`define EBM_LEVEL_HIGH_MV     16'h0abe
`define EBM_HYST_MV           16'h0096
// Enable pin threshold in millivolts
`define EBM_ENABLE_THRESH_MV  16'h044c
// Configuration word field positions
`define EBM_CFG_MON_EN_BIT    0
`define EBM_CFG_LEVEL_SEL_BIT 1
`define EBM_CFG_DEFAULTS_LSB  8
`define EBM_CFG_DEFAULTS_MSB  15
// Fixed hardware defaults
`define EBM_HW_DEFAULTS       8'h5a
// Least reset hold time in ns and its cycle count at 100 MHz
`define EBM_CLK_PERIOD_NS     10
`define EBM_HOLD_NS           100
`define EBM_HOLD_CYCLES       ((`EBM_HOLD_NS + `EBM_CLK_PERIOD_NS - 1) / `EBM_CLK_PERIOD_NS)

`endif

// ---- pkg/ebm_pkg.sv ----
// Types shared by the reset sequencer files.
// Assumes ebm_params.svh supplies the numeric constants.
package ebm_pkg;
   typedef enum logic [3:0] {
      EBM_POWER_DOWN = 4'h1,
      EBM_MONITOR    = 4'h2,
      EBM_HOLD       = 4'h4,
      EBM_RUN        = 4'h8
   } ebm_state_e;

   typedef logic [15:0] ebm_mv_t;
endpackage

// ---- design/ebm_battery_cmp.sv ----
// Battery comparator with two selectable critical levels and hysteresis.
// Assumes the battery level arrives as a millivolt code synchronous to clk.
`timescale 1ns/1ps
`include "ebm_params.svh"

module ebm_battery_cmp (
   input  wire logic           clk,
   input  wire logic           rst_b,
   input  wire logic           enable,
   input  wire logic           level_sel,
   input  wire ebm_pkg::ebm_mv_t battery_mv,
   output logic                battery_low
);
   ebm_pkg::ebm_mv_t battery_critical_level;
   ebm_pkg::ebm_mv_t release_level;
   logic             low_q;

   assign battery_critical_level = level_sel ? ebm_pkg::ebm_mv_t'(`EBM_LEVEL_HIGH_MV)
                                             : ebm_pkg::ebm_mv_t'(`EBM_LEVEL_LOW_MV);
   assign release_level = battery_critical_level + ebm_pkg::ebm_mv_t'(`EBM_HYST_MV);

   // Evaluated every cycle, not only at start-up
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         low_q <= 1'b0;
      end else if (!enable) begin
         low_q <= 1'b0;
      end else if (!low_q && battery_mv < battery_critical_level) begin
         low_q <= 1'b1;
      end else if (low_q && battery_mv >= release_level) begin
         low_q <= 1'b0;
      end
   end

   assign battery_low = low_q;

   hyst_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      (low_q && enable && battery_mv < release_level) |=> low_q)
      else $error("battery low flag dropped inside hysteresis band");
endmodule // ebm_battery_cmp

// ---- design/ebm_iface_latch.sv ----
// Latch of host interface selection pins, taken as reset ends.
// Assumes the select pins are synchronous to clk.
`timescale 1ns/1ps

module ebm_iface_latch #(
   parameter int SEL_W = 2
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             capture,
   input  wire logic             pad_lost,
   input  wire logic [SEL_W-1:0] sel_pins,
   output logic      [SEL_W-1:0] sel_q,
   output logic                  sel_valid
);
   if (SEL_W < 1) begin : g_bad_width
      $error("SEL_W must be at least 1");
   end

   logic valid_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sel_q <= '0;
      end else if (capture) begin
         sel_q <= sel_pins;
      end
   end

   // Pad loss wins over capture: a selection taken while unbiased is untrusted
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         valid_q <= 1'b0;
      end else if (pad_lost) begin
         valid_q <= 1'b0;
      end else if (capture) begin
         valid_q <= 1'b1;
      end
   end

   assign sel_valid = valid_q;

   pad_invalid_a: assert property (@(posedge clk) disable iff (!rst_b)
      pad_lost |=> !sel_valid)
      else $error("selection still valid after pad supply loss");
endmodule // ebm_iface_latch

// ---- test/ebm_host_model.sv ----
// Host model: drives enable pin, battery rail and pad supply of the sequencer.
// Assumes the bench requests levels at posedge clk; outputs follow one cycle later.
`timescale 1ns/1ps

module ebm_host_model #(
   parameter int REBOOT_CYC = 4
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             en_req,
   input  wire ebm_pkg::ebm_mv_t bat_req,
   input  wire logic             pad_req,
   output logic                  chip_enable_pin,
   output ebm_pkg::ebm_mv_t      battery_mv,
   output logic                  pad_supply_ok
);
   logic [3:0] reboot_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         battery_mv    <= 16'h0000;
         pad_supply_ok <= 1'b0;
      end else begin
         battery_mv    <= bat_req;
         pad_supply_ok <= pad_req;
      end
   end

   // Pad back while enabled: pull enable low once to force a reboot
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reboot_q <= 4'h0;
      end else if (pad_req && !pad_supply_ok && chip_enable_pin) begin
         reboot_q <= 4'(REBOOT_CYC);
      end else if (reboot_q != 4'h0) begin
         reboot_q <= reboot_q - 4'h1;
      end
   end

   // Enable only once the battery rail is up
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chip_enable_pin <= 1'b0;
      end else begin
         chip_enable_pin <= en_req && (battery_mv != 16'h0000) && (reboot_q == 4'h0);
      end
   end
endmodule // ebm_host_model

// ---- test/ebm_reset_seq_bench.sv ----
// Self-checking bench for the reset sequencer with a host model.
// Assumes ebm_params.svh on the include path; hold count shortened to 3.
`timescale 1ns/1ps
`include "ebm_params.svh"

module ebm_reset_seq_bench;
   localparam int HOLD = 3;
   logic             clk, rst_b, en_req, pad_req, cfg_loaded;
   ebm_pkg::ebm_mv_t bat_req;
   logic [15:0]      cfg_word;
   logic [1:0]       sel_pins;
   logic             chip_enable_pin, pad_supply_ok, core_rst_b, fw_restart;
   logic             hard_power_down, monitor_state, monitor_enabled, iface_sel_valid;
   ebm_pkg::ebm_mv_t battery_mv;
   logic [7:0]       cfg_defaults, hw_defaults;
   logic [1:0]       iface_sel;
   ebm_pkg::ebm_state_e state;
   int               fails, n_tests, cycles;

   ebm_host_model host (.clk(clk), .rst_b(rst_b), .en_req(en_req), .bat_req(bat_req),
      .pad_req(pad_req), .chip_enable_pin(chip_enable_pin), .battery_mv(battery_mv),
      .pad_supply_ok(pad_supply_ok));

   ebm_reset_seq #(.SEL_W(2), .HOLD_COUNT(HOLD)) dut (.clk(clk), .rst_b(rst_b),
      .chip_enable_pin(chip_enable_pin), .battery_mv(battery_mv),
      .pad_supply_ok(pad_supply_ok), .cfg_loaded(cfg_loaded), .cfg_word(cfg_word),
      .iface_sel_pins(sel_pins), .core_rst_b(core_rst_b), .fw_restart(fw_restart),
      .hard_power_down(hard_power_down), .monitor_state(monitor_state),
      .monitor_enabled(monitor_enabled), .cfg_defaults(cfg_defaults),
      .hw_defaults(hw_defaults), .iface_sel(iface_sel),
      .iface_sel_valid(iface_sel_valid), .state(state));

   always #5 clk = ~clk;

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Ceiling well above the roughly 130 cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         end_of_test();
      end
   end

   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic load_cfg(logic [15:0] w);
      @(posedge clk);
      cfg_word   <= w;
      cfg_loaded <= 1'b1;
      @(posedge clk);
      cfg_loaded <= 1'b0;
      cyc(3);
   endtask

   // Counts cycles until release; hold must outlast the hold count
   task automatic wait_run();
      int n;
      n = 0;
      while (core_rst_b !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      check("hold_len", 16'(n > HOLD), 16'h0001);
      check("fw_restart", 16'(fw_restart), 16'h0001);
      check("state_run", 16'(state), 16'(ebm_pkg::EBM_RUN));
      check("hw_defaults", 16'(hw_defaults), 16'h005a);
      cyc(1);
      check("fw_pulse", 16'(fw_restart), 16'h0000);
   endtask

   task automatic t_boot();
      check("mon_off", 16'(monitor_enabled), 16'h0000);
      check("pd_boot", 16'(hard_power_down), 16'h0001);
      load_cfg(16'ha500);
      @(posedge clk);
      bat_req <= 16'h07d0;
      en_req  <= 1'b1;
      #1;
      wait_run();
      check("no_mon", 16'(monitor_state), 16'h0000);
      check("cfg_def", 16'(cfg_defaults), 16'h00a5);
      check("sel", 16'(iface_sel), 16'h0002);
      check("sel_valid", 16'(iface_sel_valid), 16'h0001);
      $display("test boot done");
   endtask

   task automatic t_enable_low();
      @(posedge clk);
      en_req <= 1'b0;
      cyc(4);
      check("pd", 16'(hard_power_down), 16'h0001);
      check("pd_rst", 16'(core_rst_b), 16'h0000);
      check("def_rst", 16'(cfg_defaults), 16'h0000);
      @(posedge clk);
      en_req <= 1'b1;
      #1;
      wait_run();
      $display("test enable low done");
   endtask

   task automatic t_bat(logic lsel, ebm_pkg::ebm_mv_t crit);
      // Start above both levels so monitor entry can only come from the drop
      @(posedge clk);
      bat_req <= 16'h0ce4;
      load_cfg(16'h3c01 | 16'(lsel) << 1);
      check("mon_en", 16'(monitor_enabled), 16'h0001);
      check("pre_mon", 16'(monitor_state), 16'h0000);
      @(posedge clk);
      bat_req <= crit - 16'h0064;
      cyc(5);
      check("mon", 16'(monitor_state), 16'h0001);
      check("mon_rst", 16'(core_rst_b), 16'h0000);
      @(posedge clk);
      bat_req <= crit + 16'h0064;
      cyc(6);
      check("hyst", 16'(monitor_state), 16'h0001);
      @(posedge clk);
      bat_req <= crit + 16'h00fa;
      #1;
      wait_run();
      check("cfg_def2", 16'(cfg_defaults), 16'h003c);
      $display("test battery level %0d done", lsel);
   endtask

   task automatic t_mon_en_low();
      @(posedge clk);
      bat_req <= 16'h0800;
      cyc(5);
      check("mon2", 16'(monitor_state), 16'h0001);
      @(posedge clk);
      en_req <= 1'b0;
      cyc(4);
      check("pd_over_mon", 16'(hard_power_down), 16'h0001);
      check("not_mon", 16'(monitor_state), 16'h0000);
      @(posedge clk);
      bat_req <= 16'h0ce4;
      en_req  <= 1'b1;
      #1;
      wait_run();
      $display("test monitor with enable low done");
   endtask

   task automatic t_pad();
      @(posedge clk);
      pad_req  <= 1'b0;
      sel_pins <= 2'h1;
      cyc(4);
      check("pad_lost", 16'(iface_sel_valid), 16'h0000);
      @(posedge clk);
      pad_req <= 1'b1;
      cyc(3);
      check("reboot", 16'(core_rst_b), 16'h0000);
      wait_run();
      check("resel", 16'(iface_sel), 16'h0001);
      check("revalid", 16'(iface_sel_valid), 16'h0001);
      $display("test pad loss done");
   endtask

   initial begin
      clk        = 1'b0;
      rst_b      = 1'b0;
      en_req     = 1'b0;
      pad_req    = 1'b1;
      cfg_loaded = 1'b0;
      cfg_word   = 16'h0000;
      bat_req    = 16'h0000;
      sel_pins   = 2'h2;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      cyc(2);
      t_boot();
      t_enable_low();
      t_bat(1'b0, `EBM_LEVEL_LOW_MV);
      t_bat(1'b1, `EBM_LEVEL_HIGH_MV);
      t_mon_en_low();
      t_pad();
      end_of_test();
   end
endmodule // ebm_reset_seq_bench
